// *** logic/meter_ctrl_consts.vh ***
// Purpose: constants for the meter acquisition-control register block
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: readings are 32-bit two's complement fixed-point words
`ifndef METER_CTRL_CONSTS_VH
`define METER_CTRL_CONSTS_VH
// =====================================
// register byte offsets
`define OFS_GAIN_RANGE 8'h00
`define OFS_REF_VALUE 8'h04
`define OFS_REF_CAPTURE 8'h08
`define OFS_RUN_CONTROL 8'h0c
`define OFS_AREA 8'h10
`define OFS_STAT_MAX 8'h14
`define OFS_STAT_MIN 8'h18
`define OFS_STAT_SPREAD 8'h1c
`define OFS_STAT_MEAN 8'h20
`define OFS_STAT_DEV 8'h24
`define OFS_TRIG_BEGIN 8'h28
`define OFS_TRIG_END 8'h2c
`define OFS_TRIG_STATE 8'h30
`define OFS_UNIT 8'h34
`define OFS_STATUS 8'h38
`define OFS_LAST_READING 8'h3c
`define OFS_STAT_CLEAR 8'h40
// =====================================
// limits and codes
`define RANGE_MAX_THERMAL 3'h5
`define RANGE_MAX_PHOTO 3'h4
`define TRIG_SEL_MAX 3'h6
`define TRIG_BEGIN_MAX 3'h3
`define TRIG_CONT 3'h0
`define TRIG_KEY 3'h2
`define TRIG_STATE_CMD 3'h3
`define UNIT_W_CM2 4'h3
`define UNIT_J_CM2 4'h5
`define UNIT_DBM 4'h6
`define UNIT_SUN 4'hb
`define UNIT_RESET 4'h2
// status word field positions
`define STS_UNIT_LO 7
`define STS_RANGE_LO 4
`define STS_PRESENT_BIT 3
`define STS_RANGING_BIT 2
`define STS_SAT_BIT 1
`define STS_OVER_BIT 0
// statistics buffer depth (log2)
`define STAT_DEPTH_LOG2 4
`define STAT_DEPTH 16
`endif

// *** logic/meter_range_trigger_control.v ***
// Purpose: acquisition control, reference, statistics and trigger registers
// Assumes: wishbone classic slave, one clock, synchronous active-high reset
// Notes: ack comes one cycle after request; ack drops the cycle after
// =====================================
//
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "meter_ctrl_consts.vh"

module meter_range_trigger_control (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // sensor side
  input wire photodiode_i,
  input wire present_i,
  input wire [31:0] sensor_area_i,
  input wire sample_valid_i,
  input wire [31:0] sample_i,
  input wire overrange_i,
  input wire ranging_i,
  input wire soft_key_i,
  // control outputs
  output reg acquire_o,
  output reg area_in_use_o,
  output reg [2:0] gain_range_o,
  output reg [3:0] unit_o,
  output reg [31:0] reference_o
);

  // =====================================
  // unit code check
  function unit_ok;
    input [3:0] u;
    begin
      unit_ok = (u <= `UNIT_DBM) || (u == `UNIT_SUN);
    end
  endfunction

  function trig_sel_ok;
    input [2:0] s;
    begin
      trig_sel_ok = (s != 3'h1) && (s <= `TRIG_SEL_MAX);
    end
  endfunction

  // =====================================
  // pin synchronisers
  reg [4:0] pin_meta_reg;
  reg [4:0] pin_sync_reg;
  reg key_prev_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_reg <= 5'h00;
      pin_sync_reg <= 5'h00;
      key_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= {soft_key_i, ranging_i, overrange_i, present_i, photodiode_i};
      pin_sync_reg <= pin_meta_reg;
      key_prev_reg <= pin_sync_reg[4];
    end
  end
  wire photo_s = pin_sync_reg[0];
  wire present_s = pin_sync_reg[1];
  wire over_s = pin_sync_reg[2];
  wire ranging_s = pin_sync_reg[3];
  wire key_press = pin_sync_reg[4] & ~key_prev_reg;
  wire [2:0] range_limit = photo_s ? `RANGE_MAX_PHOTO : `RANGE_MAX_THERMAL;

  // =====================================
  // bus decode
  wire req = cyc_i & stb_i & ~ack_o;
  wire wr = cyc_i & stb_i & ack_o & we_i & (sel_i == 4'hf);
  wire rd = req & ~we_i;

  // =====================================
  // settings
  reg [2:0] range_reg;
  reg [31:0] ref_reg;
  reg run_reg;
  reg [31:0] area_reg;
  reg area_set_reg;
  reg [2:0] begin_reg;
  reg [2:0] end_reg;
  reg state_reg;
  reg [3:0] unit_reg;
  reg [31:0] last_reg;
  reg stat_clear;
  wire acquiring;

  always @(posedge clk_i) begin
    if (rst_i) begin
      range_reg <= 3'h0;
      ref_reg <= 32'h0000_0000;
      run_reg <= 1'b1;
      area_reg <= 32'h0000_0000;
      area_set_reg <= 1'b0;
      begin_reg <= `TRIG_CONT;
      end_reg <= `TRIG_CONT;
      state_reg <= 1'b0;
      unit_reg <= `UNIT_RESET;
      last_reg <= 32'h0000_0000;
    end else begin
      if (acquiring && sample_valid_i) begin
        last_reg <= sample_i;
      end
      if (!area_set_reg) begin
        area_reg <= sensor_area_i;
      end
      if (range_reg > range_limit) begin
        range_reg <= range_limit;
      end
      // trigger events from the soft key
      if (key_press && !state_reg && begin_reg == `TRIG_KEY) begin
        state_reg <= 1'b1;
      end
      if (key_press && state_reg && end_reg == `TRIG_KEY) begin
        state_reg <= 1'b0;
      end
      if (wr) begin
        case (adr_i)
          `OFS_GAIN_RANGE: begin
            if (dat_i[31:3] == 29'h0 && dat_i[2:0] <= range_limit) begin
              range_reg <= dat_i[2:0];
            end
          end
          `OFS_REF_VALUE: begin
            ref_reg <= dat_i;
          end
          `OFS_REF_CAPTURE: begin
            ref_reg <= last_reg;
          end
          `OFS_RUN_CONTROL: begin
            if (dat_i[31:1] == 31'h0) begin
              run_reg <= dat_i[0];
            end
          end
          `OFS_AREA: begin
            area_reg <= dat_i;
            area_set_reg <= 1'b1;
          end
          `OFS_TRIG_BEGIN: begin
            if (dat_i[31:3] == 29'h0 && trig_sel_ok(dat_i[2:0]) &&
              dat_i[2:0] <= `TRIG_BEGIN_MAX) begin
              begin_reg <= dat_i[2:0];
            end
          end
          `OFS_TRIG_END: begin
            if (dat_i[31:3] == 29'h0 && trig_sel_ok(dat_i[2:0])) begin
              end_reg <= dat_i[2:0];
            end
          end
          `OFS_TRIG_STATE: begin
            if (dat_i[31:1] == 31'h0) begin
              if (dat_i[0] && begin_reg == `TRIG_STATE_CMD) begin
                state_reg <= 1'b1;
              end else if (!dat_i[0] && (end_reg == `TRIG_STATE_CMD || !state_reg)) begin
                state_reg <= 1'b0;
              end else begin
                state_reg <= dat_i[0];
              end
            end
          end
          `OFS_UNIT: begin
            if (dat_i[31:4] == 28'h0 && unit_ok(dat_i[3:0])) begin
              unit_reg <= dat_i[3:0];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      stat_clear <= 1'b0;
    end else begin
      stat_clear <= wr && (adr_i == `OFS_STAT_CLEAR);
    end
  end

  // continuous begin selector needs no arming
  assign acquiring = run_reg && ((begin_reg == `TRIG_CONT) || state_reg);

  // =====================================
  // statistics buffer
  reg [31:0] buf_mem [0:`STAT_DEPTH-1];
  reg [`STAT_DEPTH_LOG2-1:0] wptr_reg;
  reg [`STAT_DEPTH_LOG2:0] count_reg;
  reg signed [31:0] max_reg;
  reg signed [31:0] min_reg;
  reg signed [31:0] mean_reg;
  reg [31:0] dev_reg;
  wire take = acquiring && sample_valid_i;

  always @(posedge clk_i) begin
    if (take) begin
      buf_mem[wptr_reg] <= sample_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i || stat_clear) begin
      wptr_reg <= {`STAT_DEPTH_LOG2{1'b0}};
      count_reg <= {(`STAT_DEPTH_LOG2+1){1'b0}};
    end else if (take) begin
      wptr_reg <= wptr_reg + 1'b1;
      if (count_reg != `STAT_DEPTH) begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  // combinational reduction over the valid entries
  reg signed [31:0] c_max;
  reg signed [31:0] c_min;
  reg signed [39:0] c_sum;
  reg signed [79:0] c_sq;
  reg signed [31:0] c_mean;
  reg signed [31:0] c_diff;
  reg signed [39:0] c_quot;
  integer i;
  always @* begin
    c_max = 32'sh8000_0000;
    c_min = 32'sh7fff_ffff;
    c_sum = 40'sh00_0000_0000;
    c_sq = 80'sh0;
    c_diff = 32'sh0;
    c_quot = 40'sh0;
    for (i = 0; i < `STAT_DEPTH; i = i + 1) begin
      if (i < count_reg) begin
        if ($signed(buf_mem[i]) > c_max) c_max = $signed(buf_mem[i]);
        if ($signed(buf_mem[i]) < c_min) c_min = $signed(buf_mem[i]);
        c_sum = c_sum + {{8{buf_mem[i][31]}}, buf_mem[i]};
      end
    end
    if (count_reg == 0) begin
      c_mean = 32'sh0;
    end else begin
      c_quot = c_sum / $signed({35'h0, count_reg});
      c_mean = c_quot[31:0];
    end
    for (i = 0; i < `STAT_DEPTH; i = i + 1) begin
      if (i < count_reg) begin
        c_diff = $signed(buf_mem[i]) - c_mean;
        c_sq = c_sq + c_diff * c_diff;
      end
    end
    if (count_reg == 0) begin
      c_max = 32'sh0;
      c_min = 32'sh0;
    end
  end

  // integer square root of the variance
  reg [63:0] var_w;
  reg [31:0] root;
  reg [31:0] trial;
  integer b;
  always @* begin
    var_w = (count_reg == 0) ? 64'h0 : c_sq[63:0] / {59'h0, count_reg};
    root = 32'h0;
    trial = 32'h0;
    for (b = 31; b >= 0; b = b - 1) begin
      trial = root | (32'h1 << b);
      if ({32'h0, trial} * {32'h0, trial} <= var_w) root = trial;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      max_reg <= 32'sh0;
      min_reg <= 32'sh0;
      mean_reg <= 32'sh0;
      dev_reg <= 32'h0;
    end else begin
      max_reg <= c_max;
      min_reg <= c_min;
      mean_reg <= c_mean;
      dev_reg <= root;
    end
  end

  // =====================================
  // status word and read mux
  wire [31:0] status_word = {21'h0, unit_reg, range_reg, present_s, ranging_s,
    over_s, over_s};

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      if (rd) begin
        case (adr_i)
          `OFS_GAIN_RANGE: dat_o <= {29'h0, range_reg};
          `OFS_REF_VALUE: dat_o <= ref_reg;
          `OFS_RUN_CONTROL: dat_o <= {31'h0, run_reg};
          `OFS_AREA: dat_o <= area_reg;
          `OFS_STAT_MAX: dat_o <= max_reg;
          `OFS_STAT_MIN: dat_o <= min_reg;
          `OFS_STAT_SPREAD: dat_o <= max_reg - min_reg;
          `OFS_STAT_MEAN: dat_o <= mean_reg;
          `OFS_STAT_DEV: dat_o <= dev_reg;
          `OFS_TRIG_BEGIN: dat_o <= {29'h0, begin_reg};
          `OFS_TRIG_END: dat_o <= {29'h0, end_reg};
          `OFS_TRIG_STATE: dat_o <= {31'h0, state_reg};
          `OFS_UNIT: dat_o <= {28'h0, unit_reg};
          `OFS_STATUS: dat_o <= status_word;
          `OFS_LAST_READING: dat_o <= last_reg;
          default: dat_o <= 32'h0000_0000;
        endcase
      end else begin
        dat_o <= 32'h0000_0000;
      end
    end
  end

  // =====================================
  // registered control outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      acquire_o <= 1'b0;
      area_in_use_o <= 1'b0;
      gain_range_o <= 3'h0;
      unit_o <= `UNIT_RESET;
      reference_o <= 32'h0000_0000;
    end else begin
      acquire_o <= acquiring;
      area_in_use_o <= (unit_reg == `UNIT_W_CM2) || (unit_reg == `UNIT_J_CM2) ||
        (unit_reg == `UNIT_SUN);
      gain_range_o <= range_reg;
      unit_o <= unit_reg;
      reference_o <= ref_reg;
    end
  end

endmodule

// *** tb/meter_range_trigger_control_properties.sv ***
// Purpose: port checks for the meter control block
// Assumes: one clock, sync active-high reset
// Notes: ack comes one cycle after a request is taken
`timescale 1ns/1ps
module meter_range_trigger_control_properties (
  // clock and bus
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  // sensor and control
  input wire photodiode_i,
  input wire acquire_o,
  input wire area_in_use_o,
  input wire [2:0] gain_range_o,
  input wire [3:0] unit_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // =====================================
  // sequences
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_wr(a, d);
    s_req ##0 we_i && sel_i == 4'hf && adr_i == a && dat_i == d;
  endsequence
  sequence s_pd;
    $rose(photodiode_i) ##1 photodiode_i [*5];
  endsequence
  // =====================================
  // properties
  property p_ack; s_req |=> ack_o; endproperty
  property p_clamp; s_pd |-> gain_range_o <= 3'h4; endproperty
  property p_reject; s_wr(8'h00, 32'h6) |=> $stable(gain_range_o) [*3]; endproperty
  property p_unit; s_wr(8'h34, 32'hb) |-> ##[1:3] unit_o == 4'hb; endproperty
  property p_area;
    $changed(unit_o) |-> ##[0:2] area_in_use_o == (unit_o inside {4'h3, 4'h5, 4'hb});
  endproperty
  property p_halt; s_wr(8'h0c, 32'h0) |-> ##[1:3] !acquire_o; endproperty
  property p_status;
    ack_o && !we_i && adr_i == 8'h38 |-> dat_o[10:4] == {unit_o, gain_range_o};
  endproperty
  property p_hole; ack_o && !we_i && adr_i > 8'h40 |-> dat_o == 32'h0; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  a_clamp: assert property (p_clamp) else $error("range over limit");
  a_reject: assert property (p_reject) else $error("range taken");
  a_unit: assert property (p_unit) else $error("unit not set");
  a_area: assert property (p_area) else $error("area flag wrong");
  a_halt: assert property (p_halt) else $error("still running");
  a_status: assert property (p_status) else $error("status wrong");
  a_hole: assert property (p_hole) else $error("hole not zero");
endmodule
bind meter_range_trigger_control meter_range_trigger_control_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .photodiode_i(photodiode_i),
  .acquire_o(acquire_o), .area_in_use_o(area_in_use_o), .gain_range_o(gain_range_o),
  .unit_o(unit_o));

// *** tb/host_model.sv ***
// Purpose: classic wishbone host issuing commands
// Assumes: slave answers with ack
// Notes: write data shows inverted value when idle
`timescale 1ns/1ps
module host_model (
  // clock and answer
  input wire clk_i,
  input wire ack_i,
  input wire [31:0] rdat_i,
  // request
  output reg cyc_o = 1'b0,
  output reg stb_o = 1'b0,
  output reg we_o = 1'b0,
  output reg [7:0] adr_o = 8'h00,
  output reg [3:0] sel_o = 4'h0,
  output reg [31:0] wdat_o = 32'h0
);
  // =====================================
  // one transfer, held until ack
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    wdat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = rdat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    wdat_o <= ~d;
  endtask
endmodule

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the meter control block
// Assumes: 40 MHz clock, host model drives the bus
// Notes: sensor pins are driven here
`timescale 1ns/1ps
module testbench;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg photodiode_i = 1'b0;
  reg soft_key_i = 1'b0;
  reg sample_valid_i = 1'b0;
  reg [31:0] sample_i = 32'h0;
  wire cyc_i, stb_i, we_i, ack_o, acquire_o, area_in_use_o;
  wire [7:0] adr_i;
  wire [3:0] sel_i, unit_o;
  wire [2:0] gain_range_o;
  wire [31:0] dat_i, dat_o, reference_o;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  always #12.5 clk_i = ~clk_i;
  host_model u_host_model (.clk_i(clk_i), .ack_i(ack_o), .rdat_i(dat_o), .cyc_o(cyc_i),
    .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .wdat_o(dat_i));
  meter_range_trigger_control u_meter_range_trigger_control (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .photodiode_i(photodiode_i), .present_i(1'b1),
    .sensor_area_i(32'h55), .sample_valid_i(sample_valid_i), .sample_i(sample_i),
    .overrange_i(1'b0), .ranging_i(1'b0), .soft_key_i(soft_key_i), .acquire_o(acquire_o),
    .area_in_use_o(area_in_use_o), .gain_range_o(gain_range_o), .unit_o(unit_o),
    .reference_o(reference_o));
  // =====================================
  // helpers
  task finish_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_host_model.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    u_host_model.xfer(1'b0, a, 32'h0, q);
    cmp(q, e);
  endtask
  task automatic acq(input logic e);
    wt(3);
    cmp({31'h0, acquire_o}, {31'h0, e});
  endtask
  task automatic push(input logic [31:0] v);
    sample_i <= v;
    sample_valid_i <= 1'b1;
    wt(1);
    sample_valid_i <= 1'b0;
    wt(1);
  endtask
  task automatic key;
    soft_key_i <= 1'b1;
    wt(4);
    soft_key_i <= 1'b0;
    wt(4);
  endtask
  // =====================================
  // scenarios
  task t_reset;
    rd(8'h00, 32'h0);
    rd(8'h0c, 32'h1);
    rd(8'h28, 32'h0);
    rd(8'h2c, 32'h0);
    rd(8'h30, 32'h0);
    rd(8'h34, 32'h2);
    rd(8'h10, 32'h55);
    rd(8'h44, 32'h0);
  endtask
  task t_range;
    wr(8'h00, 32'h5);
    rd(8'h38, 32'h158);
    wr(8'h00, 32'h6);
    rd(8'h00, 32'h5);
    photodiode_i <= 1'b1;
    wt(8);
    rd(8'h00, 32'h4);
    wr(8'h00, 32'h5);
    rd(8'h00, 32'h4);
    wr(8'h00, 32'h3);
    rd(8'h00, 32'h3);
    cmp({29'h0, gain_range_o}, 32'h3);
  endtask
  task automatic t_units;
    logic [31:0] e;
    e = 32'h2;
    for (int u = 0; u < 12; u++) begin
      wr(8'h34, 32'(u));
      if (u < 7 || u == 11) e = 32'(u);
      rd(8'h34, e);
      cmp({28'h0, unit_o}, e);
      cmp({31'h0, area_in_use_o}, {31'h0, (e == 32'h3) || (e == 32'h5) || (e == 32'hb)});
    end
    wr(8'h34, 32'h2);
    wr(8'h10, 32'h77);
    rd(8'h10, 32'h77);
  endtask
  task t_ref;
    wr(8'h04, 32'h1234);
    rd(8'h04, 32'h1234);
    cmp(reference_o, 32'h1234);
    push(32'hfffffff0);
    wr(8'h08, 32'h0);
    rd(8'h04, 32'hfffffff0);
  endtask
  task t_stats;
    wr(8'h40, 32'h0);
    wt(3);
    push(32'hffffffec);
    push(32'd10);
    push(32'd30);
    push(32'd40);
    wt(3);
    rd(8'h14, 32'h28);
    rd(8'h18, 32'hffffffec);
    rd(8'h1c, 32'h3c);
    rd(8'h20, 32'hf);
    rd(8'h24, 32'h16);
    rd(8'h3c, 32'h28);
  endtask
  task t_run;
    wr(8'h0c, 32'h0);
    rd(8'h0c, 32'h0);
    acq(1'b0);
    wr(8'h0c, 32'h1);
    rd(8'h0c, 32'h1);
    acq(1'b1);
  endtask
  task t_trig;
    wr(8'h28, 32'h1);
    rd(8'h28, 32'h0);
    wr(8'h28, 32'h3);
    rd(8'h28, 32'h3);
    wr(8'h28, 32'h4);
    rd(8'h28, 32'h3);
    acq(1'b0);
    wr(8'h30, 32'h1);
    acq(1'b1);
    wr(8'h30, 32'h2);
    rd(8'h30, 32'h1);
    wr(8'h2c, 32'h1);
    rd(8'h2c, 32'h0);
    wr(8'h2c, 32'h3);
    rd(8'h2c, 32'h3);
    wr(8'h30, 32'h0);
    acq(1'b0);
    wr(8'h28, 32'h2);
    wr(8'h2c, 32'h2);
    key();
    acq(1'b1);
    key();
    acq(1'b0);
    wr(8'h28, 32'h0);
    acq(1'b1);
  endtask
  // =====================================
  // run control
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    wt(2);
    rst_i <= 1'b0;
    t_reset();
    t_range();
    t_units();
    t_ref();
    t_stats();
    t_run();
    t_trig();
    finish_test();
  end
endmodule
